// ---- src/cdt_timer.sv ----
// configurable down-counting interval timer with apb registers
// Function
// [R1] counter, period and capture width is 8, 16, 24 or 32 bits at build
// [R2] hardened variant allows only 8 and 16 bit widths
// [R3] period register holds period minus one and is the reload value
// [R4] period is at most two to the power of the width
// [R5] with a trigger mode, counting waits for the chosen trigger edge; hardened build ignores the trigger
// [R6] software trigger mode selects none/rise/fall/either, defaults to none
// [R7] capture input sampled on rising clock edge, edges found from samples
// [R8] when enabled, chosen capture edge stores the current count
// [R9] hardened variant offers only no capture or rising capture
// [R10] software capture mode selects none/rise/fall/either, defaults to none
// [R11] optional event counter captures only after programmed event count
// [R12] capture event count accepts 2 to 127, writable at run time; hardened build ignores writes
// [R13] hardware enable sampled on rising clock edge
// [R14] enable from control bit, hardware input, or both, chosen at build; hardened build turns hardware-only into control bit
// [R15] continuous mode counts as long as enabled
// [R16] one-shot stops at zero, reloads period, restarts only after reset
// [R17] halt mode also stops on interrupt, reloading period; hardened build runs halt as one-shot
// [R18] interrupt enables: terminal count, 1-4 captures, fifo full; reset off
// [R19] outside logic should start one-shot via trigger or software enable
// [R20] reset loads period into counter and clears capture event counter
// [R21] terminal count output high while count is zero
// [R22] interrupt stays high until status register is read
// [R23] when disabled, counter holds and outputs keep their values; a software capture still updates capture_out and irq
// [R24] counter decrements each edge; continuous reloads the period after zero
// [R25] capture fifo holds four values, full when fourth written unread
`timescale 1ns/1ns
`include "cdt_params.svh"
module cdt_timer #(
    parameter int                     WIDTH     = 8,
    parameter bit                     HARDENED  = 1'b0,
    parameter longint unsigned        PERIOD    = 256,
    parameter cdt_pkg::cdt_edge_t     TRIG_MODE = cdt_pkg::EDGE_NONE,
    parameter bit                     TRIG_SW   = 1'b0,
    parameter cdt_pkg::cdt_edge_t     CAP_MODE  = cdt_pkg::EDGE_RISE,
    parameter bit                     CAP_SW    = 1'b0,
    parameter cdt_pkg::cdt_en_mode_t  EN_MODE   = cdt_pkg::EN_SW,
    parameter cdt_pkg::cdt_run_mode_t RUN_MODE  = cdt_pkg::RUN_CONT,
    parameter logic [6:0]             CAP_COUNT = `CDT_CC_MIN
) (
    // clock, reset, clock enable
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // hardware inputs from neighbouring logic
    input  wire logic        trigger,
    input  wire logic        capture,
    input  wire logic        enable,
    // event outputs
    output logic             count_zero_flag,
    output logic             capture_out,
    output logic             irq
);
    // ----------------------------------------
    // build-time restrictions per variant
    // ----------------------------------------
    localparam logic [WIDTH-1:0] PER_M1 = WIDTH'(PERIOD - 1); // [R3]
    localparam bit HAS_TRIG = !HARDENED && (TRIG_SW || TRIG_MODE != cdt_pkg::EDGE_NONE);
    localparam cdt_pkg::cdt_run_mode_t RUN_EFF =
        (HARDENED && RUN_MODE == cdt_pkg::RUN_HALT) ? cdt_pkg::RUN_ONESHOT : RUN_MODE; // [R17]
    localparam cdt_pkg::cdt_en_mode_t EN_EFF =
        (HARDENED && EN_MODE == cdt_pkg::EN_HW) ? cdt_pkg::EN_SW : EN_MODE; // [R14]

    // edge detect on synchronised samples, used by trigger and capture
    function automatic logic edge_hit(cdt_pkg::cdt_edge_t m, logic cur, logic prv);
        case (m)
            cdt_pkg::EDGE_RISE:   edge_hit = cur & ~prv;
            cdt_pkg::EDGE_FALL:   edge_hit = ~cur & prv;
            cdt_pkg::EDGE_EITHER: edge_hit = cur ^ prv;
            default:              edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [2:0]          in_s1_q, in_s2_q, in_s3_q;
    logic [WIDTH-1:0]    cnt_q, cnt_d, per_q;
    cdt_pkg::cdt_state_t st_q;
    logic                ctrl_en_q;
    cdt_pkg::cdt_edge_t  ctrl_trig_q, ctrl_cap_q;
    logic [4:0]          imask_q;
    logic [2:0]          stat_q, stat_set;
    logic [6:0]          cc_val_q, evt_q;
    logic                cc_en_q;
    logic [WIDTH-1:0]    fifo_q [0:3];
    logic [1:0]          wp_q, rp_q;
    logic [2:0]          lvl_q, since_q;
    logic                tc_q, irq_q, capo_q, pready_q, pslverr_q, pop_ok_q;
    logic [31:0]         prdata_q;
    // ----------------------------------------
    // decoded strobes
    // ----------------------------------------
    logic acc, wr_done, rd_done, map_ok, st_clr, pop, push, fclr, swcap;
    logic [2:0] clr_bits;
    logic en, trig_hw, cap_hw, en_hw, trig_now, evt, cap_now;
    cdt_pkg::cdt_edge_t trig_m, cap_m;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    // three stages: s1 only feeds s2, s3 gives the previous sample for edges
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            in_s1_q <= 3'h0;
            in_s2_q <= 3'h0;
            in_s3_q <= 3'h0;
        end else if (ce) begin
            in_s1_q <= {trigger, capture, enable}; // [R7] [R13]
            in_s2_q <= in_s1_q;
            in_s3_q <= in_s2_q;
        end
    end
    assign en_hw = in_s2_q[0];

    // ----------------------------------------
    // mode and enable selection
    // ----------------------------------------
    always_comb begin
        trig_m = HAS_TRIG ? (TRIG_SW ? ctrl_trig_q : TRIG_MODE) : cdt_pkg::EDGE_NONE; // [R5] [R6]
        cap_m  = CAP_SW ? ctrl_cap_q : CAP_MODE; // [R10]
        // hardened block only knows rising edge capture
        if (HARDENED && cap_m != cdt_pkg::EDGE_RISE)
            cap_m = cdt_pkg::EDGE_NONE; // [R9]
        case (EN_EFF)
            cdt_pkg::EN_HW:   en = en_hw;
            cdt_pkg::EN_BOTH: en = en_hw & ctrl_en_q;
            default:          en = ctrl_en_q;
        endcase // [R14]
    end
    assign trig_hw  = edge_hit(trig_m, in_s2_q[2], in_s3_q[2]);
    assign cap_hw   = edge_hit(cap_m, in_s2_q[1], in_s3_q[1]);
    assign trig_now = (trig_m == cdt_pkg::EDGE_NONE) || trig_hw; // [R5]

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    assign acc     = psel & penable & pready_q;
    assign wr_done = acc & pwrite;
    assign rd_done = acc & ~pwrite;
    assign map_ok  = paddr inside {`CDT_OFF_CTRL, `CDT_OFF_IMASK, `CDT_OFF_STATUS,
                     `CDT_OFF_PERIOD, `CDT_OFF_COUNT, `CDT_OFF_CAPT, `CDT_OFF_CCOUNT};
    assign st_clr  = rd_done && paddr == `CDT_OFF_STATUS;
    // a read clears and pops only what it reported; events after the data load survive
    assign clr_bits = {3{st_clr}} & prdata_q[2:0];
    assign pop     = rd_done && pop_ok_q;
    assign fclr    = wr_done && paddr == `CDT_OFF_CTRL && pwdata[`CDT_CTRL_FCLR];
    assign swcap   = wr_done && paddr == `CDT_OFF_CTRL && pwdata[`CDT_CTRL_SWCAP];

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
            pop_ok_q  <= 1'b0;
        end else if (ce) begin
            pready_q  <= psel & penable & ~pready_q;
            pop_ok_q  <= psel && penable && !pready_q && !pwrite && paddr == `CDT_OFF_CAPT && lvl_q != 3'h0;
            pslverr_q <= psel & penable & ~pready_q & ~map_ok;
            prdata_q  <= 32'h0;
            if (psel && penable && !pready_q && !pwrite) begin
                case (paddr)
                    `CDT_OFF_CTRL:   prdata_q <= 32'({ctrl_cap_q, ctrl_trig_q, ctrl_en_q});
                    `CDT_OFF_IMASK:  prdata_q <= 32'(imask_q);
                    `CDT_OFF_STATUS: prdata_q <= 32'({lvl_q != 3'h0, stat_q});
                    `CDT_OFF_PERIOD: prdata_q <= 32'(per_q);
                    `CDT_OFF_COUNT:  prdata_q <= 32'(cnt_q);
                    `CDT_OFF_CAPT:   prdata_q <= (lvl_q != 3'h0) ? 32'(fifo_q[rp_q]) : 32'h0; // empty reads zero
                    `CDT_OFF_CCOUNT: prdata_q <= 32'({cc_en_q, cc_val_q});
                    default:         prdata_q <= 32'h0;
                endcase
            end
        end
    end

    // ----------------------------------------
    // software registers
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_en_q   <= 1'b0;
            ctrl_trig_q <= cdt_pkg::EDGE_NONE; // [R6]
            ctrl_cap_q  <= cdt_pkg::EDGE_NONE; // [R10]
            imask_q     <= `CDT_IMASK_RST;     // [R18]
            per_q       <= PER_M1;             // [R3]
            cc_val_q    <= CAP_COUNT;
            cc_en_q     <= 1'b0;
        end else if (ce && wr_done) begin
            case (paddr)
                `CDT_OFF_CTRL: begin
                    ctrl_en_q   <= pwdata[`CDT_CTRL_EN];
                    ctrl_trig_q <= cdt_pkg::cdt_edge_t'(pwdata[`CDT_CTRL_TRIG +: 2]);
                    ctrl_cap_q  <= cdt_pkg::cdt_edge_t'(pwdata[`CDT_CTRL_CAP +: 2]);
                end
                `CDT_OFF_IMASK:  imask_q <= pwdata[4:0]; // [R18]
                `CDT_OFF_PERIOD: per_q   <= pwdata[WIDTH-1:0];
                `CDT_OFF_CCOUNT: begin
                    // out-of-range counts are ignored, the old value stays
                    if (!HARDENED && pwdata[6:0] >= `CDT_CC_MIN)
                        cc_val_q <= pwdata[6:0]; // [R12]
                    cc_en_q <= !HARDENED && pwdata[`CDT_CC_EN]; // [R11]
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // run state and down counter
    // ----------------------------------------
    always_comb begin
        cnt_d = cnt_q;
        if (en && st_q == cdt_pkg::ST_RUN) begin
            if (cnt_q == '0)
                cnt_d = per_q; // [R24] [R16] [R17]
            else if (RUN_EFF == cdt_pkg::RUN_HALT && irq_q)
                cnt_d = per_q; // [R17]
            else
                cnt_d = cnt_q - 1'b1; // [R24]
        end
    end

    // counter and run state freeze while disabled
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt_q <= PER_M1; // [R20]
            st_q  <= cdt_pkg::ST_ARMED;
            tc_q  <= 1'b0;
        end else if (ce) begin
            cnt_q <= cnt_d; // [R23]
            tc_q  <= cnt_d == '0; // [R21]
            if (en) begin
                case (st_q)
                    cdt_pkg::ST_ARMED:
                        if (trig_now) st_q <= cdt_pkg::ST_RUN; // [R5]
                    cdt_pkg::ST_RUN: // [R15]
                        if (RUN_EFF != cdt_pkg::RUN_CONT && cnt_q == '0)
                            st_q <= cdt_pkg::ST_DONE; // [R16]
                        else if (RUN_EFF == cdt_pkg::RUN_HALT && irq_q)
                            st_q <= cdt_pkg::ST_DONE; // [R17]
                    cdt_pkg::ST_DONE: st_q <= cdt_pkg::ST_DONE; // only reset restarts
                    default: st_q <= cdt_pkg::ST_ARMED;
                endcase
            end
        end
    end

    // ----------------------------------------
    // capture path
    // ----------------------------------------
    assign evt     = en && cap_hw; // [R8]
    assign cap_now = (evt && (!cc_en_q || evt_q + 7'h1 >= cc_val_q)) || swcap; // [R11]
    assign push    = cap_now && lvl_q != `CDT_FIFO_DEPTH;

    // capture event prescaler
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            evt_q <= 7'h0; // [R20]
        end else if (ce && evt && cc_en_q) begin
            evt_q <= (evt_q + 7'h1 >= cc_val_q) ? 7'h0 : evt_q + 7'h1; // [R11]
        end
    end

    // four-deep fifo; captures into a full fifo are dropped
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wp_q  <= 2'h0;
            rp_q  <= 2'h0;
            lvl_q <= 3'h0;
        end else if (ce) begin
            if (fclr) begin
                wp_q  <= 2'h0;
                rp_q  <= 2'h0;
                lvl_q <= 3'h0;
            end else begin
                if (push) wp_q <= wp_q + 2'h1;
                if (pop) rp_q <= rp_q + 2'h1;
                lvl_q <= 3'(lvl_q + {2'h0, push} - {2'h0, pop}); // [R25]
            end
        end
    end

    // storage has no reset, it is qualified by the level
    always_ff @(posedge sys_clk) begin
        if (ce && push && !rst) fifo_q[wp_q] <= cnt_q; // [R8]
    end

    // ----------------------------------------
    // sticky status and interrupt
    // ----------------------------------------
    always_comb begin
        stat_set               = 3'h0;
        stat_set[`CDT_IRQ_TC]  = cnt_d == '0 && cnt_q != '0;
        stat_set[`CDT_IRQ_CAP] = cap_now && since_q >= {1'b0, imask_q[`CDT_IRQ_CNT +: 2]};
        stat_set[`CDT_IRQ_FULL] = push && lvl_q == `CDT_FIFO_DEPTH - 3'h1; // [R25]
    end

    // set wins over a read that clears in the same cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stat_q  <= 3'h0;
            since_q <= 3'h0;
            irq_q   <= 1'b0;
            capo_q  <= 1'b0;
        end else if (ce) begin
            stat_q  <= (stat_q & ~clr_bits) | stat_set; // [R22]
            if (stat_set[`CDT_IRQ_CAP] || st_clr)
                since_q <= 3'h0;
            else if (cap_now && since_q != 3'h7)
                since_q <= since_q + 3'h1;
            irq_q  <= |(((stat_q & ~clr_bits) | stat_set) & imask_q[2:0]); // [R18] [R22]
            capo_q <= cap_now;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign prdata          = prdata_q;
    assign pready          = pready_q;
    assign pslverr         = pslverr_q;
    assign count_zero_flag = tc_q;
    assign capture_out     = capo_q;
    assign irq             = irq_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    AST_BUILD_LIMITS: assert property (@(posedge sys_clk) // [R1] [R2] [R4]
        WIDTH inside {8, 16, 24, 32} && (!HARDENED || WIDTH <= 16) && PERIOD <= (64'h1 << WIDTH))
        else $error("illegal width or period");
    AST_TC_ZERO: assert property (@(posedge sys_clk) disable iff (rst) // [R21]
        ##1 tc_q == (cnt_q == '0)) else $error("terminal count mismatch");
    AST_HOLD_OFF: assert property (@(posedge sys_clk) disable iff (rst) // [R23]
        !en |=> $stable(cnt_q) && $stable(tc_q)) else $error("count moved while disabled");
    AST_DECREMENT: assert property (@(posedge sys_clk) disable iff (rst) // [R24]
        ce && en && st_q == cdt_pkg::ST_RUN && cnt_q != '0 && !(RUN_EFF == cdt_pkg::RUN_HALT && irq_q)
        |=> cnt_q == $past(cnt_q) - 1'b1) else $error("no decrement");
    AST_RELOAD: assert property (@(posedge sys_clk) disable iff (rst) // [R15] [R24]
        ce && en && st_q == cdt_pkg::ST_RUN && cnt_q == '0 |=> cnt_q == $past(per_q))
        else $error("no reload after zero");
    AST_ONESHOT: assert property (@(posedge sys_clk) disable iff (rst) // [R16]
        ce && en && st_q == cdt_pkg::ST_RUN && cnt_q == '0 && RUN_EFF != cdt_pkg::RUN_CONT
        |=> st_q == cdt_pkg::ST_DONE ##1 $stable(cnt_q)) else $error("one-shot did not stop");
    AST_RESET_LOAD: assert property (@(posedge sys_clk) // [R20] [R6] [R10] [R18]
        rst |=> cnt_q == PER_M1 && evt_q == 7'h0 && imask_q == `CDT_IMASK_RST
        && ctrl_trig_q == cdt_pkg::EDGE_NONE && ctrl_cap_q == cdt_pkg::EDGE_NONE)
        else $error("reset values wrong");
    AST_ARMED_WAIT: assert property (@(posedge sys_clk) disable iff (rst) // [R5]
        st_q == cdt_pkg::ST_ARMED |=> $stable(cnt_q)) else $error("counted before trigger");
    AST_IRQ_STICKY: assert property (@(posedge sys_clk) disable iff (rst) // [R22]
        ce && irq_q && !st_clr && $stable(imask_q) |=> irq_q) else $error("interrupt dropped");
    AST_CAP_VALUE: assert property (@(posedge sys_clk) disable iff (rst) // [R8]
        ce && push |=> fifo_q[$past(wp_q)] == $past(cnt_q)) else $error("wrong value captured");
    AST_FIFO_FULL: assert property (@(posedge sys_clk) disable iff (rst) // [R25]
        ce && push && !fclr && lvl_q == 3'h3 && !pop |=> lvl_q == 3'h4 && stat_q[`CDT_IRQ_FULL])
        else $error("fifo full not flagged");
    AST_CC_RANGE: assert property (@(posedge sys_clk) disable iff (rst) // [R12]
        cc_val_q >= `CDT_CC_MIN && cc_val_q <= `CDT_CC_MAX) else $error("capture count out of range");
    COV_RELOAD: cover property (@(posedge sys_clk) disable iff (rst)
        st_q == cdt_pkg::ST_RUN && cnt_q == '0 ##1 cnt_q == per_q);
    COV_FULL: cover property (@(posedge sys_clk) disable iff (rst) lvl_q == 3'h4);
    COV_IRQ_CLR: cover property (@(posedge sys_clk) disable iff (rst) irq_q ##1 st_clr ##1 !irq_q);
endmodule : cdt_timer

// ---- src/cdt_params.svh ----
// register offsets, field positions and reset values of the down timer
`ifndef CDT_PARAMS_SVH
`define CDT_PARAMS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CDT_OFF_CTRL    8'h00
`define CDT_OFF_IMASK   8'h04
`define CDT_OFF_STATUS  8'h08
`define CDT_OFF_PERIOD  8'h0c
`define CDT_OFF_COUNT   8'h10
`define CDT_OFF_CAPT    8'h14
`define CDT_OFF_CCOUNT  8'h18
// ----------------------------------------
// control fields
// ----------------------------------------
`define CDT_CTRL_EN     0
`define CDT_CTRL_TRIG   1
`define CDT_CTRL_CAP    3
`define CDT_CTRL_SWCAP  5
`define CDT_CTRL_FCLR   6
// ----------------------------------------
// mask, status and capture count fields
// ----------------------------------------
`define CDT_IRQ_TC      0
`define CDT_IRQ_CAP     1
`define CDT_IRQ_FULL    2
`define CDT_IRQ_CNT     3
`define CDT_ST_NEMPTY   3
`define CDT_CC_EN       7
// ----------------------------------------
// limits and reset values
// ----------------------------------------
`define CDT_CC_MIN      7'h02
`define CDT_CC_MAX      7'h7f
`define CDT_FIFO_DEPTH  3'h4
`define CDT_IMASK_RST   5'h00
`endif

// ---- src/cdt_pkg.sv ----
// types shared by the down timer
package cdt_pkg;
    // edge selection for trigger and capture
    typedef enum logic [1:0] {
        EDGE_NONE   = 2'h0,
        EDGE_RISE   = 2'h1,
        EDGE_FALL   = 2'h2,
        EDGE_EITHER = 2'h3
    } cdt_edge_t;
    // build-time run mode
    typedef enum logic [1:0] {
        RUN_CONT    = 2'h0,
        RUN_ONESHOT = 2'h1,
        RUN_HALT    = 2'h2
    } cdt_run_mode_t;
    // build-time enable source
    typedef enum logic [1:0] {
        EN_SW   = 2'h0,
        EN_HW   = 2'h1,
        EN_BOTH = 2'h2
    } cdt_en_mode_t;
    // run state, gray along armed, run, done
    typedef enum logic [1:0] {
        ST_ARMED = 2'h0,
        ST_RUN   = 2'h1,
        ST_DONE  = 2'h3
    } cdt_state_t;
endpackage : cdt_pkg

// ---- testbench/cdt_neighbour.sv ----
// neighbouring logic model that drives the timer's hardware inputs
`timescale 1ns/1ns
module cdt_neighbour (
    // clock, reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // requests from the bench
    input  wire logic slow,
    input  wire logic en_req,
    input  wire logic cap_req,
    input  wire logic trig_req,
    // pins towards the timer
    output logic      enable = 1'b0,
    output logic      capture = 1'b0,
    output logic      trigger = 1'b0
);
    logic [2:0] req_q = 3'h0;
    // extra stage so a slow neighbour answers one cycle late
    always @(posedge sys_clk) begin
        req_q <= rst ? 3'h0 : {en_req, cap_req, trig_req};
    end
    // pins change only just after an edge, like registered logic
    always @(posedge sys_clk) begin
        {enable, capture, trigger} <= slow ? req_q : {en_req, cap_req, trig_req};
    end
endmodule : cdt_neighbour

// ---- testbench/configurable_down_timer_test.sv ----
// self-checking bench for the down timer
`timescale 1ns/1ns
`include "cdt_params.svh"
module configurable_down_timer_test;
    localparam int P = 16;
    typedef struct {logic [7:0] a; logic [31:0] e;} cdt_row_t;
    cdt_row_t rows [5] = '{'{8'h00, 32'h0}, '{8'h04, 32'h0}, '{8'h08, 32'h0}, '{8'h0c, 32'(P - 1)},
                           '{8'h10, 32'(P - 1)}};
    logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err, slow = 1'b0, ce = 1'b1;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, prev;
    logic pready, pslverr, trigger, capture, enable, count_zero_flag, capture_out, irq, os_zero;
    logic en_req = 1'b0, cap_req = 1'b0, trig_req = 1'b0;
    int num_errors = 0, check_count = 0, cap_pulses = 0, base, n1, n2, os_tc = 0;
    always #25 sys_clk = ~sys_clk;
    // capture pulses are one cycle wide, so count them at every edge
    always @(posedge sys_clk) if (capture_out === 1'b1) cap_pulses <= cap_pulses + 1;
    // the one-shot copy must show exactly one zero before the mid-run reset
    always @(posedge sys_clk) if (os_zero === 1'b1) os_tc <= os_tc + 1;
    cdt_neighbour NB (.sys_clk(sys_clk), .rst(rst), .slow(slow), .en_req(en_req), .cap_req(cap_req),
                      .trig_req(trig_req), .enable(enable), .capture(capture), .trigger(trigger));
    cdt_timer #(.PERIOD(P), .TRIG_SW(1'b1), .CAP_SW(1'b1), .EN_MODE(cdt_pkg::EN_BOTH)) DUT (
        .sys_clk(sys_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trigger(trigger), .capture(capture), .enable(enable), .count_zero_flag(count_zero_flag),
        .capture_out(capture_out), .irq(irq));
    // one-shot copy on the same bus; software enable keeps it from starting early
    cdt_timer #(.PERIOD(P), .TRIG_SW(1'b1), .CAP_SW(1'b1), .EN_MODE(cdt_pkg::EN_BOTH),
                .RUN_MODE(cdt_pkg::RUN_ONESHOT)) DUT_ONESHOT (
        .sys_clk(sys_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(), .trigger(trigger),
        .capture(capture), .enable(enable), .count_zero_flag(os_zero), .capture_out(), .irq());
    task automatic give_verdict;
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    // apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            chk(0, 1, "apb timeout");
            give_verdict();
        end
    endtask : apb
    // bounded wait for irq (sel 1) or the zero flag (sel 0) to reach lvl
    task automatic wait_sig(input bit sel, input logic lvl, output int n);
        n = 0;
        while ((sel ? irq : count_zero_flag) !== lvl && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 200) begin
            chk(0, 1, "wait timeout");
            give_verdict();
        end
    endtask : wait_sig
    // pin pulses wide enough for the input synchronisers
    task automatic pulse_cap(input int n);
        repeat (n) begin
            cap_req <= 1'b1;
            repeat (4) @(posedge sys_clk);
            cap_req <= 1'b0;
            repeat (4) @(posedge sys_clk);
        end
        repeat (6) @(posedge sys_clk);
    endtask : pulse_cap
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            apb(1'b0, rows[i].a, 32'h0);
            chk(rd, rows[i].e, "reset value");
        end
        apb(1'b0, 8'h1c, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        // free run: flag high one cycle, period between flags
        en_req <= 1'b1;
        apb(1'b1, `CDT_OFF_CTRL, 32'h9);
        wait_sig(1'b0, 1'b1, n1);
        wait_sig(1'b0, 1'b0, n1);
        wait_sig(1'b0, 1'b1, n2);
        chk(n1, 1, "zero flag width");
        chk(n1 + n2, P, "reload period");
        // clock enable low freezes a count that would otherwise reach zero again
        ce <= 1'b0;
        repeat (16) @(posedge sys_clk);
        chk({31'h0, count_zero_flag}, 32'h0, "frozen while ce low");
        ce <= 1'b1;
        // hardware enable low: count held, captures ignored
        en_req <= 1'b0;
        repeat (4) @(posedge sys_clk);
        apb(1'b0, `CDT_OFF_COUNT, 32'h0);
        prev = rd;
        base = cap_pulses;
        pulse_cap(1);
        apb(1'b0, `CDT_OFF_COUNT, 32'h0);
        chk(rd, prev, "count held");
        chk(cap_pulses - base, 0, "capture while off");
        en_req <= 1'b1;
        for (int m = 1; m < 4; m++) begin
            apb(1'b1, `CDT_OFF_CTRL, 32'h41 | (m << 3));
            base = cap_pulses;
            pulse_cap(1);
            chk(cap_pulses - base, (m == 3) ? 2 : 1, "capture edge mode");
        end
        // four captures fill the fifo and raise irq
        apb(1'b1, `CDT_OFF_IMASK, 32'h4);
        apb(1'b1, `CDT_OFF_CTRL, 32'h49);
        pulse_cap(4);
        chk({31'h0, irq}, 32'h1, "full irq");
        apb(1'b0, `CDT_OFF_STATUS, 32'h0);
        chk(rd & 32'he, 32'he, "full status");
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0, "irq cleared by read");
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, `CDT_OFF_CAPT, 32'h0);
            if (i > 0) chk((prev - rd) & 32'hf, 32'h8, "captured count");
            prev = rd;
        end
        apb(1'b0, `CDT_OFF_STATUS, 32'h0);
        chk(rd & 32'h8, 32'h0, "fifo drained");
        // event prescaler, two events per capture
        apb(1'b1, `CDT_OFF_CCOUNT, 32'h82);
        apb(1'b1, `CDT_OFF_CCOUNT, 32'h81);
        apb(1'b0, `CDT_OFF_CCOUNT, 32'h0);
        chk(rd, 32'h82, "count below two refused");
        apb(1'b1, `CDT_OFF_CTRL, 32'h49);
        base = cap_pulses;
        pulse_cap(4);
        chk(cap_pulses - base, 2, "prescaled captures");
        apb(1'b1, `CDT_OFF_CCOUNT, 32'h2);
        // terminal count interrupt
        apb(1'b1, `CDT_OFF_IMASK, 32'h1);
        apb(1'b0, `CDT_OFF_STATUS, 32'h0);
        // the clearing edge still shows the old irq, so let it pass first
        @(posedge sys_clk);
        wait_sig(1'b1, 1'b1, n1);
        apb(1'b0, `CDT_OFF_STATUS, 32'h0);
        chk(rd & 32'h1, 32'h1, "tc status");
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0, "tc irq cleared");
        chk(os_tc, 1, "one-shot stopped after one zero");
        // reset in mid-run, then count waits for a trigger edge
        rst <= 1'b1;
        @(posedge sys_clk);
        rst <= 1'b0;
        slow <= 1'b1;
        apb(1'b1, `CDT_OFF_CTRL, 32'h3);
        repeat (5) @(posedge sys_clk);
        apb(1'b0, `CDT_OFF_COUNT, 32'h0);
        chk(rd, 32'(P - 1), "held until trigger");
        trig_req <= 1'b1;
        repeat (8) @(posedge sys_clk);
        apb(1'b0, `CDT_OFF_COUNT, 32'h0);
        chk({31'h0, rd == 32'(P - 1)}, 32'h0, "runs after trigger");
        give_verdict();
    end
endmodule : configurable_down_timer_test
